// [design/xmp_port.sv]
// External data memory port: config, on-chip RAM, off-chip sequencer.
// Assumes a core issuing one move at a time; pins resolved outside.
`timescale 1ns/10ps
`include "xmp_params.svh"
module xmp_port
	import xmp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        config_wr,
	input  wire logic [7:0]  config_data,
	input  wire logic        timing_wr,
	input  wire logic [7:0]  timing_data,
	input  wire logic        page_wr,
	input  wire logic [7:0]  page_data,
	input  wire logic        req,
	input  wire logic        req_wide,
	input  wire logic        req_write,
	input  wire logic [7:0]  req_ind,
	input  wire logic [15:0] req_data_pointer,
	input  wire logic [7:0]  req_wdata,
	output logic             busy,
	output logic             done,
	output logic [7:0]       rdata,
	output logic [7:0]       ext_mem_config,
	output logic [7:0]       ext_mem_timing,
	output logic [7:0]       external_data_ram_page_select,
	output logic [7:0]       addr_hi_out,
	output logic             addr_hi_oe_n,
	output logic [7:0]       addr_lo_out,
	output logic             addr_lo_oe_n,
	output logic [7:0]       data_out,
	output logic             data_oe_n,
	input  wire logic [7:0]  data_in,
	output logic             ale,
	output logic             rd_n,
	output logic             wr_n
);
	xmp_state_t  state;
	xmp_state_t  next_state;
	xmp_state_t  after_setup;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [3:0]  load_val;
	logic [7:0]  ram [0:4095];
	logic [15:0] ext_addr;
	logic        ext_wr;
	logic [7:0]  ext_wdata;
	logic        ext_hi;
	logic [7:0]  d1;
	logic [7:0]  d2;
	logic [7:0]  d3;
	logic [7:0]  filt;

	xmp_route_if rt ();
	xmp_router u_router (.rt(rt));

	wire        mux_mode_select    = ext_mem_config[`XMP_MUX_BIT];
	wire [1:0]  memory_mode_field  = ext_mem_config[`XMP_MODE_LSB +: 2];
	wire [1:0]  latch_pulse_width  = ext_mem_config[`XMP_ALE_LSB +: 2];
	wire [1:0]  setup_time_field   = ext_mem_timing[`XMP_SETUP_LSB +: 2];
	wire [3:0]  strobe_width_field = ext_mem_timing[`XMP_STRB_LSB +: 4];
	wire [1:0]  hold_time_field    = ext_mem_timing[`XMP_HOLD_LSB +: 2];
	wire        is_mux             = !mux_mode_select;
	wire        idle               = (state == S_IDLE);
	wire        take               = req && idle;
	wire        take_ext           = take && rt.off_chip;
	wire        take_int           = take && !rt.off_chip;
	wire        cfg_ok             = idle;
	wire [11:0] ram_idx            = rt.eff_addr[`XMP_RAM_AW-1:0];
	wire        last               = (cnt == 4'h0);

	assign rt.mode = xmp_mode_t'(memory_mode_field);
	assign rt.wide = req_wide;
	assign rt.page = external_data_ram_page_select;
	assign rt.ind  = req_ind;
	assign rt.data_pointer = req_data_pointer;

	// Configuration, written only between moves
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ext_mem_config   <= `XMP_CFG_RESET;
			ext_mem_timing   <= `XMP_TIM_RESET;
			external_data_ram_page_select <= `XMP_PAGE_RESET;
		end else begin
			if (config_wr && cfg_ok)
				ext_mem_config <= {3'h0, config_data[4:0]};
			if (timing_wr && cfg_ok)
				ext_mem_timing <= timing_data;
			if (page_wr && cfg_ok)
				external_data_ram_page_select <= page_data;
		end
	end

	// On-chip RAM
	always_ff @(posedge core_clk) begin
		if (take_int && req_write)
			ram[ram_idx] <= req_wdata;
	end

	// Pin input synchroniser with agreement filter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			d1   <= 8'h00;
			d2   <= 8'h00;
			d3   <= 8'h00;
			filt <= 8'h00;
		end else begin
			d1 <= data_in;
			d2 <= d1;
			d3 <= d2;
			if (d2 == d3)
				filt <= d3;
		end
	end

	assign after_setup = is_mux ? S_ALEH : S_STROBE;

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE:    if (take_ext) next_state = S_START;
			S_START:   next_state = (setup_time_field != 2'h0) ? S_SETUP : after_setup;
			S_SETUP:   if (last) next_state = after_setup;
			S_ALEH:    if (last) next_state = S_ALEL;
			S_ALEL:    if (last) next_state = S_STROBE;
			S_STROBE:  if (last) next_state = S_TURN;
			S_TURN:    next_state = (hold_time_field != 2'h0) ? S_HOLD : S_RELEASE;
			S_HOLD:    if (last) next_state = S_RELEASE;
			S_RELEASE: next_state = S_DONE;
			S_DONE:    next_state = S_IDLE;
			default:   next_state = S_IDLE;
		endcase
	end

	// Phase lengths, loaded on entry as length minus one
	always_comb begin
		case (next_state)
			S_SETUP:  load_val = {2'h0, setup_time_field} - 4'h1;
			S_ALEH:   load_val = {2'h0, latch_pulse_width};
			S_ALEL:   load_val = {2'h0, latch_pulse_width};
			S_STROBE: load_val = strobe_width_field;
			S_HOLD:   load_val = {2'h0, hold_time_field} - 4'h1;
			default:  load_val = 4'h0;
		endcase
	end
	assign next_cnt = (next_state != state) ? load_val : cnt - 4'h1;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			cnt   <= 4'h0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// Move capture
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ext_addr  <= 16'h0000;
			ext_wr    <= 1'b0;
			ext_wdata <= 8'h00;
			ext_hi    <= 1'b0;
		end else if (take_ext) begin
			ext_addr  <= rt.eff_addr;
			ext_wr    <= req_write;
			ext_wdata <= req_wdata;
			ext_hi    <= rt.drive_hi;
		end
	end

	// Pin values follow the next state so they align with it
	wire n_act   = next_state inside {S_START, S_SETUP, S_ALEH, S_ALEL, S_STROBE, S_TURN, S_HOLD};
	wire n_ad    = n_act && is_mux && (next_state inside {S_START, S_SETUP, S_ALEH, S_ALEL});
	wire n_wdrv  = ext_wr && (next_state inside {S_STROBE, S_TURN});
	wire n_strb  = (next_state == S_STROBE);
	wire n_take  = (next_state == S_START) && idle;
	wire [15:0] n_addr = n_take ? rt.eff_addr : ext_addr;
	wire n_hi    = n_take ? rt.drive_hi : ext_hi;
	wire n_wr    = n_take ? req_write : ext_wr;
	wire [7:0] n_wdata = n_take ? req_wdata : ext_wdata;

	wire       next_hi_oe_n   = !(n_act && n_hi);
	wire       next_lo_oe_n   = !(n_act && !is_mux);
	wire       next_data_oe_n = !(n_ad || (n_wr && n_strb) || n_wdrv);
	wire [7:0] next_data_out  = n_ad ? n_addr[7:0] : n_wdata;
	wire       next_ale       = (next_state == S_ALEH);
	wire       next_rd_n      = !(n_strb && !n_wr);
	wire       next_wr_n      = !(n_strb && n_wr);
	wire       next_busy      = (next_state != S_IDLE);
	wire       next_done      = (next_state == S_DONE) || take_int;
	wire       cap            = (state == S_STROBE) && last && !ext_wr;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addr_hi_out  <= 8'h00;
			addr_hi_oe_n <= 1'b1;
			addr_lo_out  <= 8'h00;
			addr_lo_oe_n <= 1'b1;
			data_out     <= 8'h00;
			data_oe_n    <= 1'b1;
			ale          <= 1'b0;
			rd_n         <= 1'b1;
			wr_n         <= 1'b1;
			busy         <= 1'b0;
			done         <= 1'b0;
		end else begin
			addr_hi_out  <= n_addr[15:8];
			addr_hi_oe_n <= next_hi_oe_n;
			addr_lo_out  <= n_addr[7:0];
			addr_lo_oe_n <= next_lo_oe_n;
			data_out     <= next_data_out;
			data_oe_n    <= next_data_oe_n;
			ale          <= next_ale;
			rd_n         <= next_rd_n;
			wr_n         <= next_wr_n;
			busy         <= next_busy;
			done         <= next_done;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rdata <= 8'h00;
		else if (take_int)
			rdata <= ram[ram_idx];
		else if (cap)
			rdata <= filt;
	end

	// Checking helpers
	logic [5:0] blen;
	logic [4:0] slen;
	logic [2:0] alen;
	logic       tim_written;
	wire        strb_low = !rd_n || !wr_n;
	wire [5:0]  ale_part = is_mux ? {3'h0, latch_pulse_width, 1'b0} + 6'h02 : 6'h00;
	wire [5:0]  exp_len  = {4'h0, setup_time_field} + {4'h0, hold_time_field}
		+ {2'h0, strobe_width_field} + 6'h01 + `XMP_OVERHEAD + ale_part;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			blen        <= 6'h00;
			slen        <= 5'h00;
			alen        <= 3'h0;
			tim_written <= 1'b0;
		end else begin
			blen        <= busy ? blen + 6'h01 : 6'h00;
			slen        <= strb_low ? slen + 5'h01 : 5'h00;
			alen        <= ale ? alen + 3'h1 : 3'h0;
			tim_written <= tim_written || (timing_wr && cfg_ok);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_busy_length: assert property (done && busy |-> blen + 6'h01 == exp_len)
		else $error("off-chip move length wrong");
	a_min_length: assert property (done && busy |-> blen + 6'h01 >= `XMP_MIN_NONMUX + ale_part)
		else $error("off-chip move too short");
	a_strobe_width: assert property ($fell(strb_low) |-> slen == {1'b0, strobe_width_field} + 5'h01)
		else $error("strobe width wrong");
	a_latch_width: assert property ($fell(ale) |-> alen == {1'b0, latch_pulse_width} + 3'h1)
		else $error("latch pulse width wrong");
	a_latch_mux_only: assert property (ale |-> is_mux && !data_oe_n && data_out == ext_addr[7:0])
		else $error("latch pulse outside multiplexed address phase");
	a_mux_lo_free: assert property (busy && is_mux |-> addr_lo_oe_n)
		else $error("dedicated low address driven in multiplexed mode");
	a_sep_lo_drive: assert property (!is_mux && strb_low |-> !addr_lo_oe_n && !ale)
		else $error("separate mode address not driven");
	a_hi_drive: assert property (strb_low |-> addr_hi_oe_n == !ext_hi)
		else $error("upper address drive wrong");
	a_int_only: assert property (req && idle && memory_mode_field == 2'h0 |=> done && !busy)
		else $error("internal-only move went off-chip");
	a_ext_only: assert property (req && idle && memory_mode_field == 2'h3 |=> busy)
		else $error("external-only move stayed on-chip");
	a_reset_timing: assert property (!tim_written |-> ext_mem_timing == `XMP_TIM_RESET)
		else $error("timing fields not at maximum after reset");
	a_order: assert property ($rose(busy) |-> !strb_low ##1 (!strb_low || (!is_mux && setup_time_field == 2'h0)))
		else $error("strobe before address phase");
	a_idle_quiet: assert property (!busy |-> rd_n && wr_n && !ale && data_oe_n)
		else $error("bus active while idle");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	// Pin values during the strobe
	a_wr_data: assert property (!wr_n |-> !data_oe_n && data_out == ext_wdata)
		else $error("write data not driven during strobe");
	a_rd_release: assert property (!rd_n |-> data_oe_n)
		else $error("data pins driven during read strobe");
	a_hi_value: assert property (strb_low && !addr_hi_oe_n |-> addr_hi_out == ext_addr[15:8])
		else $error("upper address value wrong");
	a_lo_value: assert property (!is_mux && strb_low |-> addr_lo_out == ext_addr[7:0])
		else $error("dedicated low address value wrong");

	c_mux_read: cover property (is_mux && $fell(rd_n));
	c_sep_write: cover property (!is_mux && $fell(wr_n));
	c_on_chip: cover property (done && !busy);
	c_split_nb: cover property (memory_mode_field == 2'h1 && busy && addr_hi_oe_n && strb_low);
	c_long_ale: cover property ($fell(ale) && latch_pulse_width == 2'h3);
endmodule

// [design/xmp_params.svh]
// Constants for the external data memory port: fields, resets, bounds.
// Assumes inclusion by the port and the router; no process lives here.
// Behaviour
// - Two pin arrangements, chosen by one bit
// - Mux select 0 shared pins, 1 separate
// - Multiplexed: data and low address share pins
// - Latch strobe high while low address shown
// - Data driven or sampled during the strobe; reads keep the pin sample taken four clocks before strobe end
// - Separate mode: dedicated pins, no latch phase
// - Mode 00: all on-chip, 4 kB wrap
// - 8-bit move: page high, indirect low
// - 16-bit move: data pointer is address
// - Mode 01: below boundary on-chip, above off-chip
// - No bank select: upper pins undriven
// - Split 16-bit: pointer routes, sixteen pins driven
// - Mode 10: page drives upper address byte
// - Mode 11: every move off-chip
// - External-only 8-bit: page ignored, upper undriven
// - External-only 16-bit: pointer drives all pins
// - Setup, hold, strobe, latch widths programmable
// - Off-chip length is parameters plus four
// - Minimum five cycles, multiplexed two more
// - Setup and hold reset to maximum
// - Latch high and low both 1 to 4
// - Strobe width is code plus one
`ifndef XMP_PARAMS_SVH
`define XMP_PARAMS_SVH
`define XMP_CFG_RESET   8'h03
`define XMP_TIM_RESET   8'hFF
`define XMP_PAGE_RESET  8'h00
`define XMP_MUX_BIT     4
`define XMP_MODE_LSB    2
`define XMP_ALE_LSB     0
`define XMP_SETUP_LSB   6
`define XMP_STRB_LSB    2
`define XMP_HOLD_LSB    0
`define XMP_RAM_BOUND   16'h1000
`define XMP_RAM_AW      12
`define XMP_OVERHEAD    6'h04
`define XMP_MIN_NONMUX  6'h05
`endif

// [design/xmp_pkg.sv]
// Types for the external data memory port.
// Assumes the constants header is compiled alongside.
package xmp_pkg;
	typedef enum logic [1:0] {XMP_INT_ONLY, XMP_SPLIT_NB, XMP_SPLIT_BS, XMP_EXT_ONLY} xmp_mode_t;
	typedef enum logic [3:0] {S_IDLE, S_START, S_SETUP, S_ALEH, S_ALEL, S_STROBE, S_TURN,
		S_HOLD, S_RELEASE, S_DONE} xmp_state_t;
endpackage

// [design/xmp_route_if.sv]
// Carrier between the sequencer and the address router.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface xmp_route_if;
	import xmp_pkg::*;
	xmp_mode_t   mode;
	logic        wide;
	logic [7:0]  page;
	logic [7:0]  ind;
	logic [15:0] data_pointer;
	logic [15:0] eff_addr;
	logic        off_chip;
	logic        drive_hi;
	modport core   (output mode, wide, page, ind, data_pointer, input eff_addr, off_chip, drive_hi);
	modport router (input mode, wide, page, ind, data_pointer, output eff_addr, off_chip, drive_hi);
endinterface

// [design/xmp_router.sv]
// Address router: effective address, on/off-chip target, upper pin drive.
// Assumes purely combinational use by the sequencer.
`timescale 1ns/10ps
`include "xmp_params.svh"
module xmp_router
	import xmp_pkg::*;
(
	xmp_route_if.router rt
);
	logic [15:0] paged;
	logic        above;

	assign paged       = {rt.page, rt.ind};
	assign rt.eff_addr = rt.wide ? rt.data_pointer : paged;
	assign above       = rt.eff_addr >= `XMP_RAM_BOUND;
	assign rt.off_chip = (rt.mode == XMP_EXT_ONLY) ||
		((rt.mode == XMP_SPLIT_NB || rt.mode == XMP_SPLIT_BS) && above);
	// Upper byte only for pointer moves or bank select
	assign rt.drive_hi = rt.wide || (rt.mode == XMP_SPLIT_BS);
endmodule

// [bench/xmp_ext_mem.sv]
// Partner model: external byte RAM plus the address latch of shared-pin mode.
// Assumes the port's pins; hi_latch stands for the upper port latches.
`timescale 1ns/10ps
module xmp_ext_mem (
	input  wire logic        core_clk,
	input  wire logic        sep,
	input  wire logic        lag,
	input  wire logic [7:0]  hi_latch,
	input  wire logic [7:0]  addr_hi_out,
	input  wire logic        addr_hi_oe_n,
	input  wire logic [7:0]  addr_lo_out,
	input  wire logic        addr_lo_oe_n,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe_n,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	output logic      [7:0]  ad_pin,
	output logic      [15:0] last_addr
);
	logic [7:0]  mem [0:65535];
	logic [7:0]  lo_latch;
	logic [7:0]  last_pin = 8'h00;
	logic [3:0]  rd_cnt = 4'h0;
	logic [7:0]  lo_pins;
	logic [15:0] addr;
	wire         mem_drive = !rd_n && rd_cnt >= {3'h0, lag};
	// Released pins show the inverse of their last level
	assign lo_pins = addr_lo_oe_n ? ~addr_lo_out : addr_lo_out;
	assign addr = {addr_hi_oe_n ? hi_latch : addr_hi_out, sep ? lo_pins : lo_latch};
	assign ad_pin = !data_oe_n ? data_out : (mem_drive ? mem[addr] : ~last_pin);
	always_latch begin
		if (ale) lo_latch <= ad_pin;
	end
	always @(posedge core_clk) begin
		last_pin <= ad_pin;
		rd_cnt <= rd_n ? 4'h0 : rd_cnt + 4'h1;
		if (!wr_n) mem[addr] <= ad_pin;
		if (!rd_n || !wr_n) last_addr <= addr;
	end
endmodule

// [bench/tb.sv]
// Self-checking bench for the external data memory port.
// Assumes the port and the partner RAM model; seed fixed.
`timescale 1ns/10ps
module tb;
	import xmp_pkg::*;
	logic        core_clk, resetn, config_wr, timing_wr, page_wr, req, req_wide, req_write;
	logic [7:0]  config_data, timing_data, page_data, req_ind, req_wdata, hi_latch;
	logic [15:0] req_data_pointer;
	logic        lag;
	wire         busy, done, addr_hi_oe_n, addr_lo_oe_n, data_oe_n, ale, rd_n, wr_n;
	wire  [7:0]  rdata, ext_mem_config, ext_mem_timing, external_data_ram_page_select;
	wire  [7:0]  addr_hi_out, addr_lo_out, data_out, ad_pin;
	wire  [15:0] last_addr;
	int          err_count = 0;
	int          total_checks = 0;
	xmp_port u_xmp_port (
		.core_clk(core_clk), .resetn(resetn), .config_wr(config_wr),
		.config_data(config_data), .timing_wr(timing_wr), .timing_data(timing_data),
		.page_wr(page_wr), .page_data(page_data), .req(req), .req_wide(req_wide),
		.req_write(req_write), .req_ind(req_ind), .req_data_pointer(req_data_pointer),
		.req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
		.ext_mem_config(ext_mem_config), .ext_mem_timing(ext_mem_timing),
		.external_data_ram_page_select(external_data_ram_page_select), .addr_hi_out(addr_hi_out),
		.addr_hi_oe_n(addr_hi_oe_n), .addr_lo_out(addr_lo_out),
		.addr_lo_oe_n(addr_lo_oe_n), .data_out(data_out), .data_oe_n(data_oe_n),
		.data_in(ad_pin), .ale(ale), .rd_n(rd_n), .wr_n(wr_n)
	);
	xmp_ext_mem u_xmp_ext_mem (
		.core_clk(core_clk), .sep(ext_mem_config[4]), .lag(lag), .hi_latch(hi_latch),
		.addr_hi_out(addr_hi_out), .addr_hi_oe_n(addr_hi_oe_n),
		.addr_lo_out(addr_lo_out), .addr_lo_oe_n(addr_lo_oe_n), .data_out(data_out),
		.data_oe_n(data_oe_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_pin(ad_pin),
		.last_addr(last_addr)
	);
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wreg(input int sel, input logic [7:0] d);
		@(negedge core_clk);
		config_data = d;
		timing_data = d;
		page_data = d;
		config_wr = (sel == 0);
		timing_wr = (sel == 1);
		page_wr = (sel == 2);
		@(negedge core_clk);
		{config_wr, timing_wr, page_wr} = 3'h0;
	endtask
	// Busy cycles counted until the done pulse
	task automatic move(input logic w, wr, input logic [7:0] ind, d, input logic [15:0] p,
		output int n);
		@(negedge core_clk);
		req = 1;
		req_wide = w;
		req_write = wr;
		req_ind = ind;
		req_data_pointer = p;
		req_wdata = d;
		n = 0;
		for (int k = 0; k < 200 && done !== 1'b1; k++) begin
			@(negedge core_clk);
			req = 0;
			n += (busy === 1'b1);
		end
		chk(done, 1, "done missing");
	endtask
	function automatic int cyc(input logic [7:0] c, t);
		return t[7:6] + t[1:0] + t[5:2] + 5 + (c[4] ? 0 : 2 * (c[1:0] + 1));
	endfunction
	always @(negedge core_clk) begin
		if (resetn && ext_mem_config[4] === 1'b1 && ale !== 1'b0) chk(ale, 0, "ale");
	end
	initial begin
		#200us;
		err_count++;
		give_verdict();
	end
	initial begin
		int n, m;
		logic [15:0] ra, ea;
		logic [7:0]  c, t, pg, ind, d;
		logic        w, off;
		{resetn, config_wr, timing_wr, page_wr, req, req_wide, req_write, lag} = 0;
		{config_data, timing_data, page_data, req_ind, req_wdata, hi_latch} = 0;
		req_data_pointer = 0;
		void'($urandom(95));
		repeat (3) @(negedge core_clk);
		resetn = 1;
		chk(ext_mem_config, 8'h03, "config reset");
		chk(ext_mem_timing, 8'hFF, "timing reset");
		chk(external_data_ram_page_select, 8'h00, "page reset");
		$display("test reset done");
		wreg(0, 8'hF0);
		chk(ext_mem_config, 8'h10, "config write");
		wreg(2, 8'h02);
		move(1, 1, 0, 8'h5A, 16'h1234, n);
		chk(16'(n), 16'h0000, "on-chip busy");
		move(0, 0, 8'h34, 0, 0, n);
		chk(rdata, 8'h5A, "page read");
		move(1, 0, 0, 0, 16'h2234, n);
		chk(rdata, 8'h5A, "wrap read");
		$display("test on-chip done");
		for (int i = 0; i < 24; i++) begin
			m = (i < 2) ? 3 : $urandom_range(1, 3);
			c = (i < 2) ? {3'h0, i[0], 4'hC} : {3'h0, 1'($urandom), 2'(m), 2'($urandom)};
			t = (i < 2) ? 8'h00 : 8'($urandom);
			pg = 8'($urandom);
			ind = 8'($urandom);
			d = 8'($urandom);
			w = 1'($urandom);
			lag = 1'($urandom);
			hi_latch = 8'($urandom);
			ra = w ? 16'($urandom) : {pg, ind};
			ea = (w || m == 2) ? ra : {hi_latch, ind};
			off = (m == 3) || (ra >= 16'h1000);
			wreg(0, c);
			wreg(2, pg);
			wreg(1, t);
			move(w, 1, ind, d, ra, n);
			chk(16'(n), off ? 16'(cyc(c, t)) : 16'h0000, "write cycles");
			if (off) chk(last_addr, ea, "write address");
			if (off) chk(u_xmp_ext_mem.mem[ea], d, "stored byte");
			t = t | 8'h20;
			wreg(1, t);
			move(w, 0, ind, 0, ra, n);
			chk(16'(n), off ? 16'(cyc(c, t)) : 16'h0000, "read cycles");
			if (off) chk(last_addr, ea, "read address");
			chk(rdata, d, "read data");
		end
		$display("test routing and timing done");
		give_verdict();
	end
endmodule
